// File: aps_config_regs.sv
// Power, sync and reference configuration bank with its serial port.
// Assumes the output width mode and the global sleep bit come from
// logic on mclk; the two shared pins come from outside the domain.
`timescale 1ns/10ps
module aps_config_regs
  import aps_pkg::*;
#(
  parameter bit FAST_GRADE = 1'b1
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Serial port pins
  input  wire logic       sclk,
  input  wire logic       sen_b,
  input  wire logic       sdin,
  output logic            sdout,
  output logic            sdout_oe,
  // Shared device pins
  input  wire logic       shared_sync_sleep_pin,
  input  wire logic       reference_buffer_pin,
  // From the rest of the converter
  input  wire logic [1:0] op_wire_mode,
  input  wire logic       global_sleep_bit,
  // Output buffer controls
  output logic            frame_clock_buf_off,
  output logic            bit_clock_buf_off,
  output logic            chan_a_lane1_buf_off,
  output logic            chan_a_lane0_buf_off,
  output logic            chan_b_lane1_buf_off,
  output logic            chan_b_lane0_buf_off,
  // Global sleep controls
  output logic            sleep_active,
  output logic            clock_buf_off,
  output logic            ref_amp_off,
  output logic            bandgap_off,
  // Sync, reference and clock selection
  output logic            sync_cmd,
  output logic [1:0]      ref_source,
  output logic            single_ended_clock,
  output logic            diff_clock_buf_off,
  // Sampling time and auto-zero
  output logic            sample_half_period,
  output logic            auto_zero_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic       pin_m, pin_s;
  logic       refpin_m, refpin_s;
  logic       wr_valid;
  aps_wr_s    wr;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] out_buf_r;
  logic [7:0] sleep_mask_r;
  logic [7:0] sync_ref_r;
  logic [7:0] sample_az_r;
  logic       sleep_nxt;
  logic       sync_nxt;
  logic       init_r;

  function automatic logic [7:0] read_reg(
    input logic [6:0] addr,
    input logic [7:0] ob,
    input logic [7:0] mk,
    input logic [7:0] sr,
    input logic [7:0] sa
  );
    case (addr)
      OFS_OUT_BUF:    read_reg = ob;
      OFS_SLEEP_MASK: read_reg = mk;
      OFS_SYNC_REF:   read_reg = sr;
      OFS_SAMPLE_AZ:  read_reg = sa;
      default:        read_reg = 8'h00;
    endcase
  endfunction : read_reg

  function automatic logic hit(input aps_wr_s w, input logic v, input logic [6:0] ofs);
    hit = v && (w.addr == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Serial port

  aps_spi_slave u_spi (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .sclk     (sclk),
    .sen_b    (sen_b),
    .sdin     (sdin),
    .sdout    (sdout),
    .sdout_oe (sdout_oe),
    .wr_valid (wr_valid),
    .wr       (wr),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  assign rd_data = read_reg(rd_addr, out_buf_r, sleep_mask_r, sync_ref_r, sample_az_r);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_m    <= 1'b0;
      pin_s    <= 1'b0;
      refpin_m <= 1'b0;
      refpin_s <= 1'b0;
    end else begin
      pin_m    <= shared_sync_sleep_pin;
      pin_s    <= pin_m;
      refpin_m <= reference_buffer_pin;
      refpin_s <= refpin_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; reserved bits stored as written so readback is honest

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_buf_r <= RST_OUT_BUF;
    end else if (hit(wr, wr_valid, OFS_OUT_BUF)) begin
      out_buf_r <= wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_mask_r <= RST_SLEEP_MASK;
    end else if (hit(wr, wr_valid, OFS_SLEEP_MASK)) begin
      sleep_mask_r <= wr.data;
    end
  end

  // Register sync bit is a level the host raises then drops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_ref_r <= RST_SYNC_REF;
    end else if (hit(wr, wr_valid, OFS_SYNC_REF)) begin
      sync_ref_r <= wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_az_r <= RST_SAMPLE_AZ;
    end else if (hit(wr, wr_valid, OFS_SAMPLE_AZ)) begin
      sample_az_r <= wr.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output lane buffers

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_clock_buf_off  <= RST_OUT_BUF[OB_FRAME];
      bit_clock_buf_off    <= RST_OUT_BUF[OB_BIT];
      chan_a_lane1_buf_off <= RST_OUT_BUF[OB_A1];
      chan_a_lane0_buf_off <= RST_OUT_BUF[OB_A0];
      chan_b_lane1_buf_off <= RST_OUT_BUF[OB_B1];
      chan_b_lane0_buf_off <= RST_OUT_BUF[OB_B0];
    end else begin
      frame_clock_buf_off  <= out_buf_r[OB_FRAME];
      bit_clock_buf_off    <= out_buf_r[OB_BIT];
      chan_a_lane0_buf_off <= out_buf_r[OB_A0];
      // Narrow modes have no use for lane 1, so its bit is overridden
      chan_a_lane1_buf_off <= out_buf_r[OB_A1] || op_wire_mode != WIRE_TWO;
      chan_b_lane1_buf_off <= out_buf_r[OB_B1] || op_wire_mode != WIRE_TWO;
      chan_b_lane0_buf_off <= out_buf_r[OB_B0] || op_wire_mode == WIRE_HALF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global sleep and sync sources

  always_comb begin
    sleep_nxt = global_sleep_bit || (pin_s && !sync_ref_r[SR_PIN_FN]);
    if (sync_ref_r[SR_SYNC_EN]) begin
      sync_nxt = sync_ref_r[SR_SYNC];
    end else begin
      sync_nxt = pin_s && sync_ref_r[SR_PIN_FN];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_active  <= 1'b0;
      clock_buf_off <= 1'b0;
      ref_amp_off   <= 1'b0;
      bandgap_off   <= 1'b0;
      sync_cmd      <= 1'b0;
    end else begin
      sleep_active  <= sleep_nxt;
      clock_buf_off <= sleep_nxt && !sleep_mask_r[MK_CLK];
      ref_amp_off   <= sleep_nxt && !sleep_mask_r[MK_REF];
      // Inverted sense: set means the bandgap goes too, at a wake-up cost
      bandgap_off   <= sleep_nxt && sleep_mask_r[MK_BG];
      sync_cmd      <= sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference and sampling clock selection

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ref_source         <= REF_INTERNAL;
      single_ended_clock <= 1'b0;
      diff_clock_buf_off <= 1'b0;
    end else begin
      if (sync_ref_r[SR_REFERENCE_BY_REGISTER]) begin
        ref_source         <= sync_ref_r[SR_REF_HI:SR_REF_LO];
        single_ended_clock <= sync_ref_r[SR_SE_CLK];
        diff_clock_buf_off <= sync_ref_r[SR_SE_CLK] || (sleep_nxt && !sleep_mask_r[MK_CLK]);
      end else begin
        ref_source         <= refpin_s ? REF_EXT_BUF : REF_INTERNAL;
        single_ended_clock <= 1'b0;
        diff_clock_buf_off <= sleep_nxt && !sleep_mask_r[MK_CLK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling time and auto-zero; auto-zero bit sense flips and delay loop bit is ignored on the slow grade

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_half_period <= 1'b0;
      auto_zero_on       <= 1'b0;
    end else begin
      // Half-period sampling is legal only below 40 MSPS; host must ensure it
      sample_half_period <= FAST_GRADE && sample_az_r[SA_DLL];
      auto_zero_on       <= FAST_GRADE ? sample_az_r[SA_AZ] : !sample_az_r[SA_AZ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      init_r <= 1'b0;
    end else begin
      init_r <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  frame_clock_off_a: assert property (
    hit(wr, wr_valid, OFS_OUT_BUF) |-> ##2 frame_clock_buf_off == $past(wr.data[OB_FRAME], 2))
    else $error("frame clock buffer does not follow its bit");

  bit_clock_off_a: assert property (
    hit(wr, wr_valid, OFS_OUT_BUF) |-> ##2 bit_clock_buf_off == $past(wr.data[OB_BIT], 2))
    else $error("bit clock buffer does not follow its bit");

  lane_a0_off_a: assert property (
    out_buf_r[OB_A0] |=> chan_a_lane0_buf_off)
    else $error("lane A0 buffer stays on with its bit set");

  lane1_auto_off_a: assert property (
    op_wire_mode != WIRE_TWO |=> chan_a_lane1_buf_off && chan_b_lane1_buf_off)
    else $error("lane 1 buffers on in narrow mode");

  half_b0_off_a: assert property (
    op_wire_mode == WIRE_HALF |=> chan_b_lane0_buf_off)
    else $error("lane B0 buffer on in half-wire mode");

  reset_values_a: assert property (
    !init_r |-> out_buf_r == RST_OUT_BUF && chan_b_lane0_buf_off && chan_b_lane1_buf_off)
    else $error("lane buffer bits wrong after reset");

  clock_buf_mask_a: assert property (
    sleep_active |-> clock_buf_off == !$past(sleep_mask_r[MK_CLK]))
    else $error("clock buffer mask not honoured in sleep");

  ref_amp_mask_a: assert property (
    sleep_active |-> ref_amp_off == !$past(sleep_mask_r[MK_REF]))
    else $error("reference amp mask not honoured in sleep");

  bandgap_mask_a: assert property (
    bandgap_off |-> sleep_active && $past(sleep_mask_r[MK_BG]))
    else $error("bandgap off without sleep and its bit");

  pin_sleep_a: assert property (
    pin_s && !sync_ref_r[SR_PIN_FN] |=> sleep_active &&
      (sync_cmd == $past(sync_ref_r[SR_SYNC_EN] && sync_ref_r[SR_SYNC])))
    else $error("shared pin high did not enter sleep");

  reg_sync_a: assert property (
    sync_ref_r[SR_SYNC_EN] |=> sync_cmd == $past(sync_ref_r[SR_SYNC]))
    else $error("register sync not taken from the sync bit");

  ref_select_a: assert property (
    sync_ref_r[SR_REFERENCE_BY_REGISTER] |=> ref_source == $past(sync_ref_r[SR_REF_HI:SR_REF_LO]))
    else $error("reference field not applied");

  se_clock_gate_a: assert property (
    single_ended_clock |-> $past(sync_ref_r[SR_REFERENCE_BY_REGISTER]) && diff_clock_buf_off)
    else $error("single-ended clock without reference control");

  no_sleep_a: assert property (
    !sleep_active |-> !clock_buf_off && !ref_amp_off && !bandgap_off)
    else $error("block powered down outside sleep");

  half_sample_a: assert property (
    sample_half_period |-> FAST_GRADE && $past(sample_az_r[SA_DLL]))
    else $error("half-period sampling without delay loop bit");

endmodule : aps_config_regs

// File: aps_config_regs_bench.sv
// Self-checking bench for the power, sync and reference configuration bank.
// Assumes the host model speaks the serial frame; other inputs move on mclk falls.
`timescale 1ns/10ps
module aps_config_regs_bench;
  import aps_pkg::*;

  localparam bit FAST = 1'b1;

  logic        mclk, rst_b, sclk, sen_b, sdin, sdout, sdout_oe;
  logic        shared_sync_sleep_pin, reference_buffer_pin, global_sleep_bit;
  logic [1:0]  op_wire_mode, ref_source;
  logic        fr_off, bc_off, a1_off, a0_off, b1_off, b0_off;
  logic        sleep_active, clock_buf_off, ref_amp_off, bandgap_off, sync_cmd;
  logic        single_ended_clock, diff_clock_buf_off, sample_half_period, auto_zero_on;
  logic [16:0] got;
  logic [15:0] lfsr_r = 16'h002A;
  logic [7:0]  rd;
  logic [6:0]  ofs [4] = '{OFS_OUT_BUF, OFS_SLEEP_MASK, OFS_SYNC_REF, OFS_SAMPLE_AZ};
  logic [7:0]  val [4] = '{RST_OUT_BUF, RST_SLEEP_MASK, RST_SYNC_REF, RST_SAMPLE_AZ};
  int          num_errors = 0;
  int          total_checks = 0;

  assign got = {fr_off, bc_off, a1_off, a0_off, b1_off, b0_off, sleep_active, clock_buf_off,
                ref_amp_off, bandgap_off, sync_cmd, ref_source, single_ended_clock,
                diff_clock_buf_off, sample_half_period, auto_zero_on};

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  aps_host_model host (.mclk(mclk), .sclk(sclk), .sen_b(sen_b), .sdin(sdin),
                       .sdout(sdout), .sdout_oe(sdout_oe));

  aps_config_regs #(.FAST_GRADE(FAST)) uut (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .sen_b(sen_b), .sdin(sdin), .sdout(sdout),
    .sdout_oe(sdout_oe), .shared_sync_sleep_pin(shared_sync_sleep_pin),
    .reference_buffer_pin(reference_buffer_pin), .op_wire_mode(op_wire_mode),
    .global_sleep_bit(global_sleep_bit), .frame_clock_buf_off(fr_off),
    .bit_clock_buf_off(bc_off), .chan_a_lane1_buf_off(a1_off), .chan_a_lane0_buf_off(a0_off),
    .chan_b_lane1_buf_off(b1_off), .chan_b_lane0_buf_off(b0_off),
    .sleep_active(sleep_active), .clock_buf_off(clock_buf_off), .ref_amp_off(ref_amp_off),
    .bandgap_off(bandgap_off), .sync_cmd(sync_cmd), .ref_source(ref_source),
    .single_ended_clock(single_ended_clock), .diff_clock_buf_off(diff_clock_buf_off),
    .sample_half_period(sample_half_period), .auto_zero_on(auto_zero_on));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Expected output vector, same order as got
  function automatic logic [16:0] exp_out(input logic [7:0] ob, mk, sr, sa,
                                          input logic [1:0] mode, input logic gsb, pin, rbp);
    logic narrow, sl, se, clk_off;
    narrow  = (mode == WIRE_ONE) || (mode == WIRE_HALF);
    sl      = gsb | (pin & ~sr[SR_PIN_FN]);
    se      = sr[SR_REFERENCE_BY_REGISTER] & sr[SR_SE_CLK];
    clk_off = sl & ~mk[MK_CLK];
    return {ob[OB_FRAME], ob[OB_BIT], ob[OB_A1] | narrow, ob[OB_A0], ob[OB_B1] | narrow,
            ob[OB_B0] | (mode == WIRE_HALF), sl, clk_off, sl & ~mk[MK_REF], sl & mk[MK_BG],
            sr[SR_SYNC_EN] ? sr[SR_SYNC] : (pin & sr[SR_PIN_FN]),
            sr[SR_REFERENCE_BY_REGISTER] ? sr[SR_REF_HI:SR_REF_LO] : {1'b0, rbp},
            se, se | clk_off, FAST & sa[SA_DLL], sa[SA_AZ]};
  endfunction : exp_out

  task automatic check(input logic [16:0] g, input logic [16:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : check

  // Pins pass two sync stages plus a register; five falls is enough
  task automatic settle_check(input string what);
    repeat (5) @(negedge mclk);
    check(got, exp_out(val[0], val[1], val[2], val[3], op_wire_mode, global_sleep_bit,
                       shared_sync_sleep_pin, reference_buffer_pin), what);
  endtask : settle_check

  task automatic write_all();
    for (int k = 0; k < 4; k++) host.access(1'b0, ofs[k], val[k], rd);
  endtask : write_all

  task automatic read_all();
    for (int k = 0; k < 4; k++) begin
      host.access(1'b1, ofs[k], 8'h00, rd);
      check({9'h000, rd}, {9'h000, val[k]}, "register readback");
      check({16'h0000, host.oe_bad}, 17'h00000, "read data enable");
    end
  endtask : read_all

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    shared_sync_sleep_pin = 1'b0;
    reference_buffer_pin  = 1'b0;
    op_wire_mode          = WIRE_TWO;
    global_sleep_bit      = 1'b0;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    settle_check("reset outputs");
    read_all();
    $display("test reset values done");
    // Half then one wire mode, buffer and sync bits clear, mask bits set; sleep from the pin, then the bit
    val = '{8'h00, 8'h0E, 8'h00, 8'h05};
    write_all();
    op_wire_mode = WIRE_HALF;
    shared_sync_sleep_pin = 1'b1;
    settle_check("half wire, pin sleep");
    op_wire_mode = WIRE_ONE;
    shared_sync_sleep_pin = 1'b0;
    global_sleep_bit = 1'b1;
    settle_check("one wire, bit sleep");
    global_sleep_bit = 1'b0;
    $display("test corner modes done");
    // Register sync: pulse high then low while the pin is high
    shared_sync_sleep_pin = 1'b1;
    val[2] = 8'hE0;
    host.access(1'b0, OFS_SYNC_REF, val[2], rd);
    settle_check("register sync high");
    val[2] = 8'hA0;
    host.access(1'b0, OFS_SYNC_REF, val[2], rd);
    settle_check("register sync low");
    $display("test register sync done");
    // Unmapped place: write ignored, read gives zero
    host.access(1'b0, 7'h0A, 8'hFF, rd);
    host.access(1'b1, 7'h0A, 8'h00, rd);
    check({9'h000, rd}, 17'h00000, "unmapped read");
    read_all();
    $display("test unmapped address done");
    for (int i = 0; i < 24; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      val[0] = lfsr_r[7:0] & 8'h3F;
      lfsr_r = lfsr_next(lfsr_r);
      val[1] = lfsr_r[7:0] & 8'h0E;
      lfsr_r = lfsr_next(lfsr_r);
      val[2] = lfsr_r[7:0] & 8'hEF;
      lfsr_r = lfsr_next(lfsr_r);
      val[3] = lfsr_r[7:0] & 8'h05;
      write_all();
      lfsr_r = lfsr_next(lfsr_r);
      op_wire_mode          = 2'(i % 3);
      global_sleep_bit      = lfsr_r[0] & lfsr_r[3];
      shared_sync_sleep_pin = lfsr_r[1];
      reference_buffer_pin  = lfsr_r[2];
      settle_check("random settings");
      read_all();
    end
    $display("test random settings done");
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : aps_config_regs_bench

// File: aps_host_model.sv
// Host side of the serial programming port of the configuration bank.
// Assumes nothing else drives sclk, sen_b or sdin; changes land on mclk falls.
`timescale 1ns/10ps
module aps_host_model
  import aps_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Serial port pins
  output logic      sclk,
  output logic      sen_b,
  output logic      sdin,
  input  wire logic sdout,
  input  wire logic sdout_oe
);
  // Sync chain needs four mclk per phase; six leaves margin
  localparam int PHASE = 6;

  // Sticky: read enable seen wrong at any bit sample
  logic oe_bad = 1'b0;

  initial begin
    sclk  = 1'b0;
    sen_b = 1'b1;
    sdin  = 1'b0;
  end

  task automatic hold_clk(input int n);
    repeat (n) @(negedge mclk);
  endtask : hold_clk

  ////////////////////////////////////////////////////////////////////////////////
  // One whole 16-bit frame; reads send zero data bits
  task automatic access(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {rd, addr, rd ? 8'h00 : wdata};
    rdata = 8'h00;
    @(negedge mclk);
    sen_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdin = frame[i];
      hold_clk(PHASE);
      if (i < 8) rdata = {rdata[6:0], sdout};
      if (sdout_oe !== (rd && i < 8)) oe_bad = 1'b1;
      sclk = 1'b1;
      hold_clk(PHASE);
      sclk = 1'b0;
    end
    // Write lands about four mclk after the last rise
    hold_clk(4);
    sen_b = 1'b1;
    // Released line must not keep its last value
    sdin = ~sdin;
    hold_clk(PHASE);
  endtask : access
endmodule : aps_host_model

// File: aps_pkg.sv
// Constants, register map and carrier types for the power, sync and
// reference configuration bank. Assumes one 20 MHz clock and a
// register reset that clears every field to its listed reset value.
package aps_pkg;

  // Register offsets on the serial port
  localparam logic [6:0] OFS_OUT_BUF    = 7'h09;
  localparam logic [6:0] OFS_SLEEP_MASK = 7'h0D;
  localparam logic [6:0] OFS_SYNC_REF   = 7'h0E;
  localparam logic [6:0] OFS_SAMPLE_AZ  = 7'h11;

  // Values after reset
  localparam logic [7:0] RST_OUT_BUF    = 8'h03;
  localparam logic [7:0] RST_SLEEP_MASK = 8'h00;
  localparam logic [7:0] RST_SYNC_REF   = 8'h00;
  localparam logic [7:0] RST_SAMPLE_AZ  = 8'h00;

  // Output buffer register fields
  localparam int OB_FRAME = 5;
  localparam int OB_BIT   = 4;
  localparam int OB_A1    = 3;
  localparam int OB_A0    = 2;
  localparam int OB_B1    = 1;
  localparam int OB_B0    = 0;
  // Sleep mask register fields
  localparam int MK_CLK   = 3;
  localparam int MK_REF   = 2;
  localparam int MK_BG    = 1;
  // Sync and reference register fields
  localparam int SR_PIN_FN  = 7;
  localparam int SR_SYNC    = 6;
  localparam int SR_SYNC_EN = 5;
  localparam int SR_REFERENCE_BY_REGISTER = 3;
  localparam int SR_REF_HI  = 2;
  localparam int SR_REF_LO  = 1;
  localparam int SR_SE_CLK  = 0;
  // Sampling time register fields
  localparam int SA_DLL   = 2;
  localparam int SA_AZ    = 0;

  // Reference source codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXT_BUF  = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  // Output interface width modes
  localparam logic [1:0] WIRE_TWO  = 2'h0;
  localparam logic [1:0] WIRE_ONE  = 2'h1;
  localparam logic [1:0] WIRE_HALF = 2'h2;

  // Serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [4:0] SPI_HDR_LEN   = 5'h08;
  localparam logic [4:0] SPI_FRAME_LEN = 5'h10;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b01,
    SPI_SHIFT = 2'b10
  } aps_spi_e;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } aps_wr_s;

endpackage : aps_pkg

// File: aps_spi_slave.sv
// Serial programming port slave for the configuration bank.
// Assumes the port pins are slow against mclk (sclk at most mclk/8);
// every pin passes two flip-flops before use.
`timescale 1ns/10ps
module aps_spi_slave
  import aps_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Serial port pins
  input  wire logic       sclk,
  input  wire logic       sen_b,
  input  wire logic       sdin,
  output logic            sdout,
  output logic            sdout_oe,
  // Register side
  output logic            wr_valid,
  output aps_wr_s         wr,
  output logic [6:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  logic       sclk_m, sclk_s, sclk_d;
  logic       sen_m, sen_s;
  logic       din_m, din_s;
  logic       rise, fall;
  aps_spi_e   state_r;
  logic [4:0] cnt_r;
  logic [6:0] sh_r;
  logic       rw_r;
  logic       ld_r;
  logic [7:0] out_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sen_m  <= 1'b1;
      sen_s  <= 1'b1;
      din_m  <= 1'b0;
      din_s  <= 1'b0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sen_m  <= sen_b;
      sen_s  <= sen_m;
      din_m  <= sdin;
      din_s  <= din_m;
    end
  end

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SPI_IDLE;
    end else begin
      case (state_r)
        SPI_IDLE:  if (!sen_s) state_r <= SPI_SHIFT;
        SPI_SHIFT: if (sen_s) state_r <= SPI_IDLE;
        default:   state_r <= SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h00;
      sh_r  <= 7'h00;
    end else if (state_r != SPI_SHIFT) begin
      cnt_r <= 5'h00;
    end else if (rise && cnt_r != SPI_FRAME_LEN) begin
      cnt_r <= 5'(cnt_r + 5'h01);
      sh_r  <= {sh_r[5:0], din_s};
    end
  end

  // Header decode; read data fetched one cycle later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rw_r    <= 1'b0;
      rd_addr <= 7'h00;
      ld_r    <= 1'b0;
    end else begin
      ld_r <= 1'b0;
      if (state_r != SPI_SHIFT) begin
        rw_r <= 1'b0;
      end else if (rise && cnt_r == 5'(SPI_HDR_LEN - 5'h01)) begin
        rw_r    <= sh_r[6];
        rd_addr <= {sh_r[5:0], din_s};
        ld_r    <= 1'b1;
      end
    end
  end

  // Read data leaves MSB first on falling edges
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_r    <= 8'h00;
      sdout    <= 1'b0;
      sdout_oe <= 1'b0;
    end else begin
      sdout_oe <= (state_r == SPI_SHIFT) && rw_r && (cnt_r >= SPI_HDR_LEN);
      if (ld_r) begin
        out_r <= rd_data;
      end else if (fall && rw_r && cnt_r >= SPI_HDR_LEN) begin
        sdout <= out_r[7];
        out_r <= {out_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_valid <= 1'b0;
      wr       <= '0;
    end else begin
      wr_valid <= 1'b0;
      if (state_r == SPI_SHIFT && rise && !rw_r && cnt_r == 5'(SPI_FRAME_LEN - 5'h01)) begin
        wr_valid <= 1'b1;
        wr.addr  <= rd_addr;
        wr.data  <= {sh_r, din_s};
      end
    end
  end

endmodule : aps_spi_slave
